// ===== design/bpc_change_bit.sv
// One change detector cell: captured copy and mismatch of a monitored pin.
`timescale 1ns/1ps
`default_nettype none
module bpc_change_bit (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Pin and control
	input wire logic pin_level,
	input wire logic is_input,
	input wire logic capture,
	// Result
	output logic mismatch
);
	logic copy_reg;
	logic copy_next;

	always_comb begin
		copy_next = copy_reg;
		if (capture) begin
			copy_next = pin_level;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			copy_reg <= 1'b0;
		end else begin
			copy_reg <= copy_next;
		end
	end

	// Output pins drop out; a pin back at its copy clears itself.
	assign mismatch = is_input && (pin_level != copy_reg);
endmodule : bpc_change_bit
`default_nettype wire

// ===== design/bpc_port.sv
// Eight-pin bidirectional port with pull-ups and change detection.
//
// Summary of operation
// - A direction bit of 1 makes the pin an input, 0 drives the latch out.
// - The output latch is readable itself, so read-modify-write uses it.
// - Clearing the shared pull-up control bit turns on the weak pull-ups of all input pins.
// - A pin configured as an output never has its pull-up on.
// - Power-on reset leaves every pull-up disabled.
// - After reset pins 4..0 are analog and read zero, pins 7..5 digital.
// - With the analog default strap cleared, pins 4..0 start digital.
// - Only input pins among 7..4 take part in change detection.
// - Input pins are compared with copies from the last port read or write, ORed to a flag.
// - The change event can wake the device from Sleep or Idle.
// - While a mismatch lasts the flag keeps being set.
// - A port access ends the mismatch one cycle later; the excluded move does not.
// - A pin returning to its copied level clears its own mismatch.
// - With the compare pin select strap at 0 and pin 3 an output, pin 3 carries the compare unit.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_regs.svh"
module bpc_port
	import bpc_pkg::*;
#(
	parameter int WIDTH = `BPC_WIDTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Configuration straps
	input wire logic analog_default_cfg,
	input wire logic compare_pin_select_cfg,
	// Software access to the port
	input wire logic port_read,
	input wire logic port_write,
	input wire logic port_access_excluded,
	input wire logic latch_read,
	input wire logic latch_write,
	input wire logic dir_write,
	input wire logic [7:0] write_data,
	input wire logic analog_select_write,
	input wire logic [7:0] analog_select_data,
	input wire logic pullup_disable_n_write,
	input wire logic pullup_disable_n_data,
	input wire logic flag_clear,
	// Alternate function from the second compare unit
	input wire logic capture_compare_second,
	// Pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pullup_on,
	// Status toward software
	output logic [7:0] read_data,
	output logic [7:0] direction_reg,
	output logic port_change_flag,
	output logic pullup_disable_n,
	output logic wake_request,
	output logic port_pin_three
);
	logic [7:0] latch_reg;
	logic [7:0] latch_next;
	logic [7:0] dir_reg;
	logic [7:0] dir_next;
	logic [7:0] analog_reg;
	logic [7:0] analog_next;
	logic pu_dis_reg;
	logic pu_dis_next;
	logic ccp_sel_reg;
	logic ccp_sel_next;
	logic flag_reg;
	logic flag_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] out_reg;
	logic [7:0] out_next;
	logic [7:0] oe_reg;
	logic [7:0] oe_next;
	logic [7:0] pu_reg;
	logic [7:0] pu_next;
	logic wake_reg;
	logic wake_next;
	logic alt_reg;
	logic alt_next;
	logic started_reg;
	logic started_next;
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	bpc_match_state_type state_reg;
	bpc_match_state_type state_next;
	logic [3:0] mism;
	logic [7:0] digital_pins;
	logic access;
	logic any_mism;

	////////////////////////////////////////////////////////////////////////
	// Change detector cells on the upper four pins.

	genvar g;
	generate
		for (g = `BPC_CHANGE_LO; g <= `BPC_CHANGE_HI; g++) begin : g_cell
			bpc_change_bit u_cell (
				.clock(clock),
				.rst_n(rst_n),
				.pin_level(pin_in[g]),
				.is_input(dir_reg[g] && !analog_reg[g]),
				.capture(access),
				.mismatch(mism[g - `BPC_CHANGE_LO])
			);
		end
	endgenerate

	// The excluded move instruction is not an access that ends a mismatch.
	assign access = (port_read || port_write) && !port_access_excluded;
	assign any_mism = |mism;
	assign digital_pins = pin_in & ~analog_reg;

	////////////////////////////////////////////////////////////////////////
	// Next state of the port.

	always_comb begin
		latch_next = latch_reg;
		dir_next = dir_reg;
		analog_next = analog_reg;
		pu_dis_next = pu_dis_reg;
		ccp_sel_next = ccp_sel_reg;
		rdata_next = rdata_reg;
		started_next = 1'b1;
		// Straps are sampled on the first clock after reset release.
		if (!started_reg) begin
			analog_next = analog_default_cfg ? `BPC_ANALOG_MASK
				: `BPC_ZERO_BYTE;
			ccp_sel_next = compare_pin_select_cfg;
		end else if (analog_select_write) begin
			analog_next = analog_select_data;
		end
		if (port_write || latch_write) begin
			latch_next = write_data;
		end
		if (dir_write) begin
			dir_next = write_data;
		end
		if (pullup_disable_n_write) begin
			pu_dis_next = pullup_disable_n_data;
		end
		if (port_read) begin
			rdata_next = digital_pins;
		end else if (latch_read) begin
			rdata_next = latch_reg;
		end
		out_next = latch_reg;
		oe_next = ~dir_reg;
		pu_next = pu_dis_reg ? `BPC_ZERO_BYTE : dir_reg;
		alt_next = !ccp_sel_reg && capture_compare_second;
		if (!ccp_sel_reg && !dir_reg[`BPC_CCP_PIN]) begin
			out_next[`BPC_CCP_PIN] = capture_compare_second;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencing: an access passes through the settle and armed states, which
	// do not gate the flag; software may clear it once the mismatch is gone.

	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		flag_next = flag_reg;
		case (state_reg)
			bpc_idle: begin
				if (access) begin
					state_next = bpc_settle;
					settle_next = `BPC_SETTLE_CYCLES;
				end
			end
			bpc_settle: begin
				if (settle_reg != 2'h0) begin
					settle_next = settle_reg - 2'h1;
				end else begin
					state_next = bpc_armed;
				end
			end
			bpc_armed: begin
				state_next = access ? bpc_settle : bpc_idle;
				settle_next = `BPC_SETTLE_CYCLES;
			end
			default: begin
				state_next = bpc_idle;
			end
		endcase
		if (flag_clear) begin
			flag_next = 1'b0;
		end
		// Set wins over a simultaneous clear while the mismatch stands.
		if (any_mism) begin
			flag_next = 1'b1;
		end
		wake_next = any_mism;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			latch_reg <= `BPC_ZERO_BYTE;
			dir_reg <= `BPC_ALL_INPUT;
			analog_reg <= `BPC_ANALOG_MASK;
			pu_dis_reg <= 1'b1;
			ccp_sel_reg <= 1'b1;
			flag_reg <= 1'b0;
			rdata_reg <= `BPC_ZERO_BYTE;
			out_reg <= `BPC_ZERO_BYTE;
			oe_reg <= `BPC_ZERO_BYTE;
			pu_reg <= `BPC_ZERO_BYTE;
			wake_reg <= 1'b0;
			alt_reg <= 1'b0;
			started_reg <= 1'b0;
			settle_reg <= 2'h0;
			state_reg <= bpc_idle;
		end else begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			analog_reg <= analog_next;
			pu_dis_reg <= pu_dis_next;
			ccp_sel_reg <= ccp_sel_next;
			flag_reg <= flag_next;
			rdata_reg <= rdata_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			pu_reg <= pu_next;
			wake_reg <= wake_next;
			alt_reg <= alt_next;
			started_reg <= started_next;
			settle_reg <= settle_next;
			state_reg <= state_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign pullup_on = pu_reg;
	assign read_data = rdata_reg;
	assign direction_reg = dir_reg;
	assign port_change_flag = flag_reg;
	assign pullup_disable_n = pu_dis_reg;
	assign wake_request = wake_reg;
	assign port_pin_three = alt_reg;
endmodule : bpc_port
`default_nettype wire

// ===== include/bpc_pkg.sv
// Types for the bidirectional port with change detection.
package bpc_pkg;
	typedef enum logic [1:0] {
		bpc_idle,
		bpc_settle,
		bpc_armed
	} bpc_match_state_type;
endpackage : bpc_pkg

// ===== include/bpc_regs.svh
// Constants for the bidirectional port with change detection.
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH
`define BPC_WIDTH 8
`define BPC_ANALOG_HI 4
`define BPC_CHANGE_LO 4
`define BPC_CHANGE_HI 7
`define BPC_CCP_PIN 3
`define BPC_PULLUP_BIT 7
`define BPC_FLAG_BIT 0
`define BPC_ALL_INPUT 8'hFF
`define BPC_ZERO_BYTE 8'h00
`define BPC_ZERO_NIB 4'h0
`define BPC_ANALOG_MASK 8'h1F
`define BPC_SETTLE_CYCLES 2'h1
`endif

// ===== verification/bpc_board.sv
// Board model that drives the port's input pins.
`timescale 1ns/1ps
`default_nettype none
module bpc_board (
	// Port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Bench side
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	// A driven pin reads back its own driver, so no contention is modelled.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : bpc_board
`default_nettype wire

// ===== verification/bpc_port_assertions.sv
// Assertions on the port's pins, reads and change flag.
`timescale 1ns/1ps
`default_nettype none
module bpc_port_assertions (
	// Watched ports
	input wire logic clock,
	input wire logic rst_n,
	input wire logic port_read,
	input wire logic port_access_excluded,
	input wire logic dir_write,
	input wire logic flag_clear,
	input wire logic [7:0] write_data,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_on,
	input wire logic [7:0] read_data,
	input wire logic [7:0] direction_reg,
	input wire logic port_change_flag,
	input wire logic pullup_disable_n,
	input wire logic wake_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	oe_dir_a: assert property (pin_oe == ~$past(direction_reg))
		else $error("pin enable wrong");
	pullup_dir_a: assert property (pullup_on ==
		($past(direction_reg) & {8{!$past(pullup_disable_n)}}))
		else $error("pull-up wrong");
	pullup_reset_a: assert property (disable iff (1'b0)
		!rst_n |=> pullup_on == 8'h00) else $error("pull-up in reset");
	dir_write_a: assert property (dir_write |=>
		direction_reg == $past(write_data)) else $error("direction wrong");
	read_pins_a: assert property (
		port_read && !port_access_excluded |=>
		((read_data ^ $past(pin_in)) & 8'hE0) == 8'h00)
		else $error("read wrong");
	flag_hold_a: assert property (
		port_change_flag && !flag_clear |=> port_change_flag)
		else $error("flag lost");
	wake_flag_a: assert property (
		wake_request |-> ##[0:2] port_change_flag) else $error("no flag");
	wake_end_a: assert property (
		port_read && !port_access_excluded ##1 $stable(pin_in) [*2]
		|-> ##[0:2] !wake_request) else $error("mismatch stays");
endmodule : bpc_port_assertions
bind bpc_port bpc_port_assertions u_chk (
	.clock(clock),
	.rst_n(rst_n),
	.port_read(port_read),
	.port_access_excluded(port_access_excluded),
	.dir_write(dir_write),
	.flag_clear(flag_clear),
	.write_data(write_data),
	.pin_in(pin_in),
	.pin_oe(pin_oe),
	.pullup_on(pullup_on),
	.read_data(read_data),
	.direction_reg(direction_reg),
	.port_change_flag(port_change_flag),
	.pullup_disable_n(pullup_disable_n),
	.wake_request(wake_request)
);
`default_nettype wire

// ===== verification/bpc_port_tb_top.sv
// Self-checking bench for the bidirectional change port.
`timescale 1ns/1ps
`default_nettype none
module bpc_port_tb_top;
	logic clock = 0, rst_n = 0, analog_default_cfg = 1;
	logic compare_pin_select_cfg = 1, capture_compare_second = 0;
	logic port_access_excluded = 0, analog_select_write = 0;
	logic port_read, port_write, latch_read, latch_write, dir_write;
	logic pullup_disable_n_write, flag_clear, pullup_disable_n_data;
	logic port_change_flag, pullup_disable_n, wake_request, port_pin_three;
	logic [6:0] stb = 0;
	logic [7:0] write_data = 0, analog_select_data = 0, ext_level = 0;
	logic [7:0] pin_in, pin_out, pin_oe, pullup_on, read_data;
	logic [7:0] direction_reg, st, m_dir, m_lat;
	int bad_count = 0, cmp_count = 0, seed = 32'h621714c3, i, c;
	assign {port_read, port_write, latch_read, latch_write, dir_write,
		pullup_disable_n_write, flag_clear} = stb;
	assign pullup_disable_n_data = write_data[0];
	assign st = {6'h0, wake_request, port_change_flag};
	always #20 clock = ~clock;
	bpc_port u_dut (
		.clock(clock),
		.rst_n(rst_n),
		.analog_default_cfg(analog_default_cfg),
		.compare_pin_select_cfg(compare_pin_select_cfg),
		.port_read(port_read),
		.port_write(port_write),
		.port_access_excluded(port_access_excluded),
		.latch_read(latch_read),
		.latch_write(latch_write),
		.dir_write(dir_write),
		.write_data(write_data),
		.analog_select_write(analog_select_write),
		.analog_select_data(analog_select_data),
		.pullup_disable_n_write(pullup_disable_n_write),
		.pullup_disable_n_data(pullup_disable_n_data),
		.flag_clear(flag_clear),
		.capture_compare_second(capture_compare_second),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pullup_on(pullup_on),
		.read_data(read_data),
		.direction_reg(direction_reg),
		.port_change_flag(port_change_flag),
		.pullup_disable_n(pullup_disable_n),
		.wake_request(wake_request),
		.port_pin_three(port_pin_three)
	);
	bpc_board u_board (
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.ext_level(ext_level),
		.pin_in(pin_in)
	);
	task step;
		@(posedge clock);
		#1;
	endtask : step
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		$display("%0d checks, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	// One strobe, then two edges so that the pins have settled.
	task pulse(input int k, input logic [7:0] d);
		write_data = d;
		stb = 7'h40 >> k;
		step;
		stb = 7'h00;
		repeat (2) step;
	endtask : pulse
	initial begin
		for (c = 0; c < 2; c++) begin
			rst_n = 0;
			analog_default_cfg = c[0];
			repeat (6) step;
			rst_n = 1;
			repeat (2) step;
			chk(pullup_on | pin_oe, 8'h00);
			ext_level = $random(seed);
			pulse(0, 8'h00);
			chk(read_data, ext_level & (c ? 8'hE0 : 8'hFF));
		end
		for (i = 0; i < 8; i++) begin
			m_dir = $random(seed);
			m_lat = $random(seed);
			pulse(4, m_dir);
			pulse(3, m_lat);
			pulse(5, m_lat);
			pulse(2, 8'h00);
			chk(read_data, m_lat);
			chk(pin_oe, ~m_dir);
			chk(direction_reg, m_dir);
			chk({7'h00, pullup_disable_n}, {7'h00, m_lat[0]});
			chk(pin_out | m_dir, m_lat | m_dir);
			chk(pullup_on, m_dir & {8{~m_lat[0]}});
		end
		// The port is read only at chosen points, never polled.
		pulse(4, 8'h7F);
		ext_level = 8'h00;
		pulse(0, 8'h00);
		pulse(6, 8'h00);
		ext_level = 8'h04;
		pulse(1, 8'h80);
		chk(st, 8'h00);
		ext_level = 8'h44;
		repeat (3) step;
		chk(st, 8'h03);
		pulse(6, 8'h00);
		chk(st, 8'h03);
		port_access_excluded = 1;
		pulse(0, 8'h00);
		port_access_excluded = 0;
		pulse(6, 8'h00);
		chk(st, 8'h03);
		ext_level = 8'h04;
		repeat (3) step;
		pulse(6, 8'h00);
		chk(st, 8'h00);
		ext_level = 8'h24;
		repeat (3) step;
		pulse(0, 8'h00);
		pulse(6, 8'h00);
		chk(st, 8'h00);
		chk(read_data, 8'hA0);
		// A port write ends a mismatch just as a read does.
		ext_level = 8'h64;
		repeat (3) step;
		chk(st, 8'h03);
		pulse(1, 8'h80);
		pulse(6, 8'h00);
		chk(st, 8'h00);
		analog_select_data = 8'h0F;
		analog_select_write = 1;
		step;
		analog_select_write = 0;
		pulse(0, 8'h00);
		chk(read_data, 8'hE0);
		// Restart with pin 3 handed to the compare unit.
		rst_n = 0;
		compare_pin_select_cfg = 0;
		repeat (6) step;
		rst_n = 1;
		repeat (2) step;
		pulse(4, 8'hF7);
		pulse(3, 8'h00);
		for (i = 0; i < 4; i++) begin
			c = $random(seed);
			capture_compare_second = c[0];
			repeat (2) step;
			chk({6'h00, port_pin_three, pin_out[3]},
				{6'h00, c[0], c[0]});
		end
		capture_compare_second = 1;
		pulse(4, 8'hFF);
		chk(pin_out, 8'h00);
		final_report;
	end
endmodule : bpc_port_tb_top
`default_nettype wire
